// ==== src/async_serial_transceiver.sv ====
// asynchronous serial transceiver with apb register slave
`timescale 1ns/10ps
`default_nettype none
module async_serial_transceiver
#(
  parameter int ADDR_W = 10
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic receive_pin,
  input wire logic sleep_req,
  output logic transmit_pin_out,
  output logic transmit_pin_oe
);
  import uart_pkg::*;

  typedef struct packed {
    logic [7:0] brg_cnt;
    logic [7:0] div;
    logic [7:0] pie;
    logic [7:0] transmit_buffer;
    logic clk_src;
    logic nine_tx;
    logic tx_en;
    logic sync_sel;
    logic high_speed;
    logic tx_ninth;
    logic port_en;
    logic nine_rx;
    logic single_rx;
    logic cont_rx;
    logic tx_full;
    logic transmit_buffer_empty_flag;
    logic [10:0] transmit_shift_register;
    logic [3:0] tx_bits;
    logic [5:0] tx_ph;
    logic tx_oe;
    logic tx_out;
    rx_state_t rx_state;
    logic [5:0] rx_ph;
    logic [3:0] rx_bits;
    logic [8:0] rx_sh;
    logic [1:0] smp;
    logic rx_prev;
    logic [1:0][9:0] fifo;
    logic [1:0] fcnt;
    logic overrun_error;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } st_t;

  st_t st_r;
  st_t st_nxt;
  logic [7:0] idx;
  logic acc;
  logic wr;
  logic rd;
  logic bt;
  logic [5:0] bl;
  logic [5:0] s0;
  logic [5:0] s1;
  logic [5:0] s2;
  logic tx_on;
  logic rx_on;
  logic wr_tx;
  logic [7:0] rdat;
  logic v;
  logic [9:0] word;
  logic transmit_buffer_empty_flag_set;

  // -------------------------------------------------------------
  // bus decode and baud timing
  // -------------------------------------------------------------
  assign idx = paddr[ADDR_W-1:2];
  assign acc = psel && penable && st_r.pready;
  assign wr = acc && pwrite && (paddr[1:0] == 2'b00);
  assign rd = acc && !pwrite && (paddr[1:0] == 2'b00);
  assign wr_tx = wr && (idx == TX_BUFFER_IDX);
  // tick every div+1 clocks, frozen while asleep
  assign bt = (st_r.brg_cnt == st_r.div) && !sleep_req;
  assign bl = st_r.high_speed ? HI_LAST : LO_LAST;
  assign s0 = st_r.high_speed ? HI_S0 : LO_S0;
  assign s1 = st_r.high_speed ? HI_S1 : LO_S1;
  assign s2 = st_r.high_speed ? HI_S2 : LO_S2;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb
  begin
    rdat = 8'h00;
    v = 1'b0;
    word = 10'h000;
    transmit_buffer_empty_flag_set = 1'b0;
    st_nxt = st_r;
    st_nxt.rx_prev = receive_pin;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    // read data is captured in the setup cycle, answer in access
    if (psel && !penable && !st_r.pready)
    begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = (paddr[1:0] != 2'b00);
      case (idx)
        FLAGS_IDX:
        begin
          rdat[RX_FULL_BIT] = (st_r.fcnt != 2'h0);
          rdat[TX_EMPTY_BIT] = st_r.transmit_buffer_empty_flag;
        end
        RX_STATUS_IDX:
        begin
          rdat[PORT_EN_BIT] = st_r.port_en;
          rdat[NINE_RX_BIT] = st_r.nine_rx;
          rdat[SINGLE_RX_BIT] = st_r.single_rx;
          rdat[CONT_RX_BIT] = st_r.cont_rx;
          rdat[FRAME_ERR_BIT] = st_r.fifo[0][9];
          rdat[OVERRUN_BIT] = st_r.overrun_error;
          rdat[RX_NINTH_BIT] = st_r.fifo[0][8];
        end
        TX_BUFFER_IDX: rdat = st_r.transmit_buffer;
        RX_BUFFER_IDX: rdat = st_r.fifo[0][7:0];
        ENABLES_IDX: rdat = st_r.pie;
        TX_STATUS_IDX:
        begin
          rdat[CLK_SRC_BIT] = st_r.clk_src;
          rdat[NINE_TX_BIT] = st_r.nine_tx;
          rdat[TX_ENABLE_BIT] = st_r.tx_en;
          rdat[SYNC_SEL_BIT] = st_r.sync_sel;
          rdat[HIGH_SPEED_BIT] = st_r.high_speed;
          rdat[SR_EMPTY_BIT] = (st_r.tx_bits == 4'h0);
          rdat[TX_NINTH_BIT] = st_r.tx_ninth;
        end
        BAUD_IDX: rdat = st_r.div;
        default: st_nxt.pslverr = 1'b1;
      endcase
      st_nxt.prdata = {24'h000000, rdat};
    end
    if (wr)
    begin
      case (idx)
        RX_STATUS_IDX:
        begin
          st_nxt.port_en = pwdata[PORT_EN_BIT];
          st_nxt.nine_rx = pwdata[NINE_RX_BIT];
          st_nxt.single_rx = pwdata[SINGLE_RX_BIT];
          st_nxt.cont_rx = pwdata[CONT_RX_BIT];
        end
        TX_BUFFER_IDX:
        begin
          st_nxt.transmit_buffer = pwdata[7:0];
          st_nxt.tx_full = 1'b1;
          st_nxt.transmit_buffer_empty_flag = 1'b0;
        end
        ENABLES_IDX: st_nxt.pie = pwdata[7:0];
        TX_STATUS_IDX:
        begin
          st_nxt.clk_src = pwdata[CLK_SRC_BIT];
          st_nxt.nine_tx = pwdata[NINE_TX_BIT];
          st_nxt.tx_en = pwdata[TX_ENABLE_BIT];
          st_nxt.sync_sel = pwdata[SYNC_SEL_BIT];
          st_nxt.high_speed = pwdata[HIGH_SPEED_BIT];
          st_nxt.tx_ninth = pwdata[TX_NINTH_BIT];
          transmit_buffer_empty_flag_set = pwdata[TX_ENABLE_BIT] && !st_r.tx_en;
        end
        BAUD_IDX: st_nxt.div = pwdata[7:0];
        default: ;
      endcase
    end
    // a read of the receive buffer pops the oldest word
    if (rd && (idx == RX_BUFFER_IDX) && (st_r.fcnt != 2'h0))
    begin
      st_nxt.fifo[0] = st_r.fifo[1];
      st_nxt.fcnt = st_r.fcnt - 2'h1;
    end

    // -----------------------------------------------------------
    // baud rate generator
    // -----------------------------------------------------------
    if (wr && (idx == BAUD_IDX))
      st_nxt.brg_cnt = 8'h00;
    else if (bt)
      st_nxt.brg_cnt = 8'h00;
    else if (!sleep_req)
      st_nxt.brg_cnt = st_r.brg_cnt + 8'h01;

    // -----------------------------------------------------------
    // transmitter
    // -----------------------------------------------------------
    tx_on = st_nxt.port_en && st_nxt.tx_en && !st_nxt.sync_sel;
    if (!tx_on)
    begin
      st_nxt.tx_bits = 4'h0;
      st_nxt.tx_ph = 6'h00;
    end
    else if (bt)
    begin
      if (st_r.tx_bits != 4'h0)
      begin
        if (st_r.tx_ph == bl)
        begin
          st_nxt.tx_ph = 6'h00;
          st_nxt.transmit_shift_register = {1'b1, st_r.transmit_shift_register[10:1]};
          st_nxt.tx_bits = st_r.tx_bits - 4'h1;
        end
        else
          st_nxt.tx_ph = st_r.tx_ph + 6'h01;
      end
      // a load in the cycle of a buffer write waits for the next tick,
      // so the empty flag never sees set and clear together
      if ((st_nxt.tx_bits == 4'h0) && st_r.tx_full && !wr_tx)
      begin
        st_nxt.transmit_shift_register = {1'b1, st_r.nine_tx ? st_r.tx_ninth : 1'b1,
                      st_r.transmit_buffer, 1'b0};
        st_nxt.tx_bits = st_r.nine_tx ? FRAME9_BITS : FRAME8_BITS;
        st_nxt.tx_ph = 6'h00;
        st_nxt.tx_full = 1'b0;
        transmit_buffer_empty_flag_set = 1'b1;
      end
    end
    if (transmit_buffer_empty_flag_set)
      st_nxt.transmit_buffer_empty_flag = 1'b1;
    st_nxt.tx_oe = tx_on;
    st_nxt.tx_out = (st_nxt.tx_bits != 4'h0) ? st_nxt.transmit_shift_register[0] : 1'b1;

    // -----------------------------------------------------------
    // receiver
    // -----------------------------------------------------------
    rx_on = st_nxt.port_en && st_nxt.cont_rx && !st_nxt.sync_sel;
    if (!rx_on)
    begin
      st_nxt.rx_state = RX_IDLE;
      st_nxt.rx_ph = 6'h00;
      st_nxt.overrun_error = 1'b0;
    end
    else
    begin
      unique case (st_r.rx_state)
        RX_IDLE:
          if (st_r.rx_prev && !receive_pin && !sleep_req)
          begin
            st_nxt.rx_state = RX_START;
            st_nxt.rx_ph = 6'h00;
            st_nxt.rx_bits = 4'h0;
          end
        RX_START, RX_DATA, RX_STOP:
          if (bt)
          begin
            st_nxt.rx_ph = (st_r.rx_ph == bl) ? 6'h00 : st_r.rx_ph + 6'h01;
            if (st_r.rx_ph == s0)
              st_nxt.smp[0] = receive_pin;
            if (st_r.rx_ph == s1)
              st_nxt.smp[1] = receive_pin;
            if (st_r.rx_ph == s2)
            begin
              v = maj3(st_r.smp[0], st_r.smp[1], receive_pin);
              if ((st_r.rx_state == RX_START) && v)
                st_nxt.rx_state = RX_IDLE;
              else if (st_r.rx_state == RX_DATA)
                st_nxt.rx_sh[st_r.rx_bits] = v;
              else if (st_r.rx_state == RX_STOP)
              begin
                word = {!v, st_r.nine_rx & st_r.rx_sh[8],
                        st_r.rx_sh[7:0]};
                st_nxt.rx_state = RX_IDLE;
                if (st_r.overrun_error)
                  st_nxt.overrun_error = 1'b1;
                else if (st_nxt.fcnt == FIFO_FULL)
                  st_nxt.overrun_error = 1'b1;
                else
                begin
                  st_nxt.fifo[st_nxt.fcnt[0]] = word;
                  st_nxt.fcnt = st_nxt.fcnt + 2'h1;
                end
              end
            end
            if ((st_r.rx_ph == bl) && (st_nxt.rx_state != RX_IDLE))
            begin
              if (st_r.rx_state == RX_START)
                st_nxt.rx_state = RX_DATA;
              else if (st_r.rx_state == RX_DATA)
              begin
                if (st_r.rx_bits == (st_r.nine_rx ? 4'h8 : 4'h7))
                  st_nxt.rx_state = RX_STOP;
                else
                  st_nxt.rx_bits = st_r.rx_bits + 4'h1;
              end
            end
          end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign transmit_pin_out = st_r.tx_out;
  assign transmit_pin_oe = st_r.tx_oe;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_abort;
    (wr && idx == TX_STATUS_IDX && !pwdata[TX_ENABLE_BIT]) |=>
      !st_r.tx_oe && st_r.tx_bits == 4'h0;
  endproperty
  a_abort: assert property (p_abort)
    else $error("transmit not aborted");
  property p_load;
    $rose(st_r.tx_bits != 4'h0) |-> st_r.transmit_buffer_empty_flag && !st_r.tx_full;
  endproperty
  a_load: assert property (p_load)
    else $error("load did not empty buffer");
  property p_start_low;
    $rose(st_r.tx_bits != 4'h0) |-> !st_r.tx_out && st_r.tx_oe;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low");
  property p_transmit_enable_flag;
    (wr && idx == TX_STATUS_IDX && pwdata[TX_ENABLE_BIT] && !st_r.tx_en)
      |=> st_r.transmit_buffer_empty_flag;
  endproperty
  a_transmit_enable_flag: assert property (p_transmit_enable_flag)
    else $error("enable did not set empty flag");
  property p_flag_clear;
    $fell(st_r.transmit_buffer_empty_flag) |-> $past(wr_tx);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("empty flag cleared without write");
  property p_fifo_depth;
    st_r.fcnt <= FIFO_FULL;
  endproperty
  a_fifo_depth: assert property (p_fifo_depth)
    else $error("fifo over two words");
  property p_overrun_error_block;
    (st_r.overrun_error && rx_on) |=> st_r.fcnt <= $past(st_r.fcnt);
  endproperty
  a_overrun_error_block: assert property (p_overrun_error_block)
    else $error("push while overrun");
  property p_full_src;
    $rose(st_r.fcnt != 2'h0) |-> $past(st_r.rx_state) == RX_STOP;
  endproperty
  a_full_src: assert property (p_full_src)
    else $error("word pushed outside stop bit");
  property p_brg_reset;
    (wr && idx == BAUD_IDX) |=> st_r.brg_cnt == 8'h00;
  endproperty
  a_brg_reset: assert property (p_brg_reset)
    else $error("baud timer not restarted");
  property p_sleep;
    (sleep_req && !wr) |=> $stable(st_r.tx_ph) && $stable(st_r.rx_ph);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("activity during sleep");
  property p_false_start;
    (rx_on && st_r.rx_state == RX_START && bt && st_r.rx_ph == s2 &&
     st_r.smp == 2'b11) |=> st_r.rx_state == RX_IDLE;
  endproperty
  a_false_start: assert property (p_false_start)
    else $error("high start vote not rejected");

  c_back_to_back: cover property
    ($fell(st_r.tx_bits != 4'h0) ##0 (st_nxt.tx_bits != 4'h0));
  c_overrun: cover property ($rose(st_r.overrun_error));
  c_frame_err: cover property ($rose(st_r.fcnt != 2'h0) ##0 st_r.fifo[0][9]);
  c_nine_rx: cover property ($rose(st_r.fcnt != 2'h0) ##0 st_r.nine_rx);
endmodule : async_serial_transceiver
`default_nettype wire

// ==== src/uart_pkg.sv ====
// constants and types of the asynchronous serial transceiver
package uart_pkg;
  // -------------------------------------------------------------
  // register indexes, byte address is four times the index
  // -------------------------------------------------------------
  localparam logic [7:0] FLAGS_IDX = 8'h0C;
  localparam logic [7:0] RX_STATUS_IDX = 8'h18;
  localparam logic [7:0] TX_BUFFER_IDX = 8'h19;
  localparam logic [7:0] RX_BUFFER_IDX = 8'h1A;
  localparam logic [7:0] ENABLES_IDX = 8'h8C;
  localparam logic [7:0] TX_STATUS_IDX = 8'h98;
  localparam logic [7:0] BAUD_IDX = 8'h99;
  // -------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------
  localparam logic [7:0] TX_STATUS_RST = 8'h02;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int RX_FULL_BIT = 5;
  localparam int TX_EMPTY_BIT = 4;
  localparam int CLK_SRC_BIT = 7;
  localparam int NINE_TX_BIT = 6;
  localparam int TX_ENABLE_BIT = 5;
  localparam int SYNC_SEL_BIT = 4;
  localparam int HIGH_SPEED_BIT = 2;
  localparam int SR_EMPTY_BIT = 1;
  localparam int TX_NINTH_BIT = 0;
  localparam int PORT_EN_BIT = 7;
  localparam int NINE_RX_BIT = 6;
  localparam int SINGLE_RX_BIT = 5;
  localparam int CONT_RX_BIT = 4;
  localparam int FRAME_ERR_BIT = 2;
  localparam int OVERRUN_BIT = 1;
  localparam int RX_NINTH_BIT = 0;
  // -------------------------------------------------------------
  // bit timing in baud ticks
  // -------------------------------------------------------------
  localparam logic [5:0] LO_LAST = 6'h3F;
  localparam logic [5:0] HI_LAST = 6'h0F;
  localparam logic [5:0] LO_S0 = 6'h1A;
  localparam logic [5:0] LO_S1 = 6'h1E;
  localparam logic [5:0] LO_S2 = 6'h22;
  localparam logic [5:0] HI_S0 = 6'h05;
  localparam logic [5:0] HI_S1 = 6'h06;
  localparam logic [5:0] HI_S2 = 6'h07;
  localparam logic [3:0] FRAME8_BITS = 4'hA;
  localparam logic [3:0] FRAME9_BITS = 4'hB;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  function automatic logic maj3(input logic a, input logic b,
                                input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3
endpackage : uart_pkg

// ==== tb/async_serial_transceiver_tb.sv ====
// self-checking bench of the asynchronous serial transceiver
`timescale 1ns/10ps
`default_nettype none
module async_serial_transceiver_tb;
  import uart_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, sleep_req, err;
  logic pready, pslverr, pin_out, pin_oe;
  wire receive_pin;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  int miscompares = 0;
  int checked = 0;
  logic [7:0] idx_tab[7] = '{FLAGS_IDX, RX_STATUS_IDX, TX_BUFFER_IDX,
    RX_BUFFER_IDX, ENABLES_IDX, TX_STATUS_IDX, BAUD_IDX};
  async_serial_transceiver dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .receive_pin(receive_pin),
    .sleep_req(sleep_req), .transmit_pin_out(pin_out),
    .transmit_pin_oe(pin_oe));
  serial_peer peer (.pclk(pclk), .tx_out(pin_out), .tx_oe(pin_oe),
    .rx_line(receive_pin));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : check
  // setup, then access held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
    begin
      miscompares++;
      finish_test();
    end
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] e,
                    input logic [7:0] m);
    apb(1'b0, idx, 8'h00);
    check(rd_data & {24'hFFFFFF, m}, {24'h000000, e & m});
  endtask : rd
  task automatic poll(input logic [7:0] idx, input logic [7:0] m,
                      input logic [7:0] v);
    int n;
    n = 0;
    apb(1'b0, idx, 8'h00);
    while ((rd_data[7:0] & m) !== v && n < 300)
    begin
      apb(1'b0, idx, 8'h00);
      n++;
    end
    check({24'h000000, rd_data[7:0] & m}, {24'h000000, v});
    if (n == 300)
      finish_test();
  endtask : poll
  // waits for the peer to decode a frame, then compares it
  task automatic check_frame(input logic [9:0] e);
    int n;
    n = 0;
    while (peer.got_q.size() == 0 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 2000)
    begin
      miscompares++;
      finish_test();
    end
    check(32'(peer.got_q.pop_front()), 32'(e));
  endtask : check_frame
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, sleep_req} = 4'h0;
    paddr = 10'h000;
    pwdata = 32'h00000000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (idx_tab[i])
      rd(idx_tab[i], (i == 5) ? TX_STATUS_RST : ZERO_RST, 8'hFF);
    check({31'h0, pin_oe}, 32'h0);
    apb(1'b0, 8'h01, 8'h00);
    check({rd_data[30:0], err}, 32'h1);
    wr(ENABLES_IDX, 8'hA5);
    rd(ENABLES_IDX, 8'hA5, 8'hFF);
    wr(BAUD_IDX, 8'h02);
    peer.bit_clks = 48;
    wr(RX_STATUS_IDX, 8'h80);
    wr(TX_STATUS_IDX, 8'h04);
    rd(FLAGS_IDX, 8'h00, 8'h10);
    wr(TX_STATUS_IDX, 8'h24);
    rd(FLAGS_IDX, 8'h10, 8'h10);
    wr(TX_BUFFER_IDX, 8'hA5);
    poll(FLAGS_IDX, 8'h10, 8'h10);
    rd(TX_STATUS_IDX, 8'h00, 8'h02);
    wr(TX_BUFFER_IDX, 8'h3C);
    rd(FLAGS_IDX, 8'h00, 8'h10);
    check_frame(10'h2A5);
    check_frame(10'h23C);
    poll(TX_STATUS_IDX, 8'h02, 8'h02);
    wr(FLAGS_IDX, 8'h00);
    rd(FLAGS_IDX, 8'h10, 8'h10);
    // data loaded before enabling waits for the enable
    wr(TX_STATUS_IDX, 8'h45);
    wr(TX_BUFFER_IDX, 8'h5A);
    repeat (100) @(posedge pclk);
    check(32'(peer.got_q.size()), 32'h0);
    peer.nine = 1'b1;
    wr(TX_STATUS_IDX, 8'h65);
    check_frame(10'h35A);
    sleep_req <= 1'b1;
    wr(TX_BUFFER_IDX, 8'h11);
    repeat (200) @(posedge pclk);
    check(32'(peer.got_q.size()), 32'h0);
    sleep_req <= 1'b0;
    check_frame(10'h311);
    wr(TX_BUFFER_IDX, 8'h22);
    repeat (150) @(posedge pclk);
    wr(TX_STATUS_IDX, 8'h45);
    check({31'h0, pin_oe}, 32'h0);
    repeat (700) @(posedge pclk);
    peer.got_q.delete();
    wr(TX_STATUS_IDX, 8'h34);
    check({31'h0, pin_oe}, 32'h0);
    wr(BAUD_IDX, 8'h00);
    wr(TX_STATUS_IDX, 8'h04);
    peer.bit_clks = 16;
    wr(RX_STATUS_IDX, 8'hD0);
    // short low pulse is voted away as a false start
    peer.rx_line <= 1'b0;
    repeat (2) @(posedge pclk);
    peer.rx_line <= 1'b1;
    repeat (40) @(posedge pclk);
    rd(FLAGS_IDX, 8'h00, 8'h20);
    peer.send(9'h15A, 1'b1);
    peer.send(9'h0C3, 1'b0);
    peer.send(9'h077, 1'b1);
    repeat (20) @(posedge pclk);
    rd(FLAGS_IDX, 8'h20, 8'h20);
    rd(RX_STATUS_IDX, 8'hD3, 8'hFF);
    rd(RX_BUFFER_IDX, 8'h5A, 8'hFF);
    rd(RX_STATUS_IDX, 8'hD6, 8'hFF);
    rd(RX_BUFFER_IDX, 8'hC3, 8'hFF);
    rd(FLAGS_IDX, 8'h00, 8'h20);
    peer.send(9'h100, 1'b1);
    repeat (20) @(posedge pclk);
    rd(FLAGS_IDX, 8'h00, 8'h20);
    wr(RX_STATUS_IDX, 8'hC0);
    wr(RX_STATUS_IDX, 8'hD0);
    rd(RX_STATUS_IDX, 8'h00, 8'h02);
    wr(TX_STATUS_IDX, 8'h00);
    peer.bit_clks = 64;
    peer.send(9'h1E7, 1'b1);
    repeat (40) @(posedge pclk);
    rd(RX_STATUS_IDX, 8'h01, 8'h07);
    rd(RX_BUFFER_IDX, 8'hE7, 8'hFF);
    finish_test();
  end
endmodule : async_serial_transceiver_tb
`default_nettype wire

// ==== tb/serial_peer.sv ====
// remote serial device model for the transceiver bench
`timescale 1ns/10ps
`default_nettype none
module serial_peer
(
  input wire logic pclk,
  input wire logic tx_out,
  input wire logic tx_oe,
  output logic rx_line
);
  int bit_clks = 16;
  logic nine = 1'b0;
  logic [9:0] got_q[$];
  logic [9:0] f;
  // released pin is pulled high
  wire line = tx_oe ? tx_out : 1'b1;
  initial rx_line = 1'b1;
  // ------------------------------------------------------------
  // sender and receiver
  // ------------------------------------------------------------
  // start low, data lsb first, stop as asked, then one idle bit
  task automatic send(input logic [8:0] d, input logic stop);
    int n;
    n = nine ? 10 : 9;
    for (int i = 0; i <= n; i++)
    begin
      @(posedge pclk);
      rx_line <= (i == 0) ? 1'b0 : (i == n) ? stop : d[i-1];
      repeat (bit_clks - 1) @(posedge pclk);
    end
    @(posedge pclk);
    rx_line <= 1'b1;
    repeat (bit_clks - 1) @(posedge pclk);
  endtask : send
  // mid-bit sampling, result kept as {stop, ninth, data}
  always
  begin
    @(negedge line);
    f = 10'h000;
    repeat (bit_clks / 2) @(posedge pclk);
    for (int i = 0; i < (nine ? 9 : 8); i++)
    begin
      repeat (bit_clks) @(posedge pclk);
      f[i] = line;
    end
    repeat (bit_clks) @(posedge pclk);
    f[9] = line;
    got_q.push_back(f);
  end
endmodule : serial_peer
`default_nettype wire
